// ### rtl/add_and_alu.sv
// Execute stage for add and AND instructions of the core
// Operation
// - Add literal adds immediate into working register
// - Add literal updates carry, digit carry, zero
// - AND literal masks working register with immediate
// - AND literal updates zero only
// - Add file adds, updates all three flags
// - AND file masks, updates zero only
// - Destination bit picks working or file register
// - Port register sources read the pins
// - Timer write clears assigned prescaler
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "alu_cfg.svh"
module add_and_alu #(
	parameter logic [6:0] TIMER_ZERO_ADDR = `TIMER_ZERO_ADDR_DFLT, // Timer zero count address
	parameter logic [6:0] PORT_A_ADDR     = `PORT_A_ADDR_DFLT,     // First port register address
	parameter logic [6:0] PORT_B_ADDR     = `PORT_B_ADDR_DFLT      // Second port register address
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [13:0] instr_word,
	output logic      [6:0]  file_raddr,
	input  wire logic [7:0]  file_rdata,
	output logic             file_we,
	output logic      [6:0]  file_waddr,
	output logic      [7:0]  file_wdata,
	input  wire logic [7:0]  port_a_pins,
	input  wire logic [7:0]  port_b_pins,
	output logic             prescaler_clr,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [7:0]  reg_rdata,
	output logic      [7:0]  w_value,
	output logic             carry_flag,
	output logic             digit_carry_flag,
	output logic             zero_flag,
	output logic             exec_done
);
	import alu_pkg::*;

	// Execute stage registers
	logic        ex_vld_r;     // Word held for execute
	logic [13:0] ex_word_r;    // Word under execute
	logic [6:0]  file_raddr_r; // Read address to file array

	// Architectural state
	logic [7:0]  w_r;          // Working register
	logic        c_r;          // Carry flag
	logic        dc_r;         // Digit carry flag
	logic        z_r;          // Zero flag

	// File write port
	logic        file_we_r;    // Write strobe
	logic [6:0]  file_waddr_r; // Write address
	logic [7:0]  file_wdata_r; // Write data
	logic        presc_clr_r;  // Prescaler clear pulse
	logic        done_r;       // Instruction retired pulse

	// Software visible control and counters
	logic [7:0]  ctrl_r;       // Enable and prescaler assignment
	logic [7:0]  exec_cnt_r;   // Retired instruction count
	logic [7:0]  foreign_cnt_r; // Words outside this block
	logic [7:0]  rdata_r;      // Read data

	// Pin synchronisers
	logic [7:0]  pa_meta_r;    // First stage, port A
	logic [7:0]  pa_sync_r;    // Second stage, port A
	logic [7:0]  pb_meta_r;    // First stage, port B
	logic [7:0]  pb_sync_r;    // Second stage, port B

	// Execute datapath nets
	logic [7:0]  src_byte;     // File operand after pin and forward select
	logic        commit;       // Instruction retires this cycle
	logic        is_file_op;   // File register form
	logic        to_file;      // Result written to file array
	logic        exec_en;      // Execution enabled by software
	logic        psa_timer;    // Prescaler assigned to timer

	exec_if ex_bus ();

	// Decode the held word
	insn_decoder u_dec (
		.ex (ex_bus)
	);

	// Adder and logic unit
	alu_core u_alu (
		.ex (ex_bus)
	);

	// Control bits
	assign exec_en   = ctrl_r[`CTRL_EN_BIT];
	assign psa_timer = ctrl_r[`CTRL_PSA_BIT];

	// Outputs straight from flip-flops
	assign file_raddr       = file_raddr_r;
	assign file_we          = file_we_r;
	assign file_waddr       = file_waddr_r;
	assign file_wdata       = file_wdata_r;
	assign prescaler_clr    = presc_clr_r;
	assign reg_rdata        = rdata_r;
	assign w_value          = w_r;
	assign carry_flag       = c_r;
	assign digit_carry_flag = dc_r;
	assign zero_flag        = z_r;
	assign exec_done        = done_r;

	// Two-stage synchronisers for the port pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_meta_r <= `BYTE_ZERO;
			pa_sync_r <= `BYTE_ZERO;
			pb_meta_r <= `BYTE_ZERO;
			pb_sync_r <= `BYTE_ZERO;
		end else begin
			pa_meta_r <= port_a_pins;
			pa_sync_r <= pa_meta_r;
			pb_meta_r <= port_b_pins;
			pb_sync_r <= pb_meta_r;
		end
	end

	// Take a word each cycle and present its file address
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ex_vld_r     <= 1'b0;
			ex_word_r    <= `WORD_ZERO;
			file_raddr_r <= `FADDR_ZERO;
		end else begin
			// One word per cycle, no stall or skip slot
			ex_vld_r <= instr_valid;
			if (instr_valid) begin
				ex_word_r    <= instr_word;
				file_raddr_r <= instr_word[`FADDR_MSB:0];
			end
		end
	end

	// Held word and working register feed the decoder and the unit
	assign ex_bus.word   = ex_word_r;
	assign ex_bus.opnd_w = w_r;

	// Operand selection for the arithmetic unit
	always_comb begin
		// Port registers read from the pins, not the latch
		if (ex_bus.faddr == PORT_A_ADDR) begin
			src_byte = pa_sync_r;
		end else if (ex_bus.faddr == PORT_B_ADDR) begin
			src_byte = pb_sync_r;
		end else if (file_we_r && (file_waddr_r == ex_bus.faddr)) begin
			// Previous result not yet in the array, forward it
			src_byte = file_wdata_r;
		end else begin
			src_byte = file_rdata;
		end
		ex_bus.opnd_s = src_byte;
		// Literal forms take the immediate byte
		if ((ex_bus.op == ADD_LITERAL_OP) || (ex_bus.op == AND_LITERAL_OP)) begin
			ex_bus.opnd_s = ex_bus.literal;
		end
	end

	// Retire and destination decisions
	assign commit     = ex_vld_r && exec_en && (ex_bus.op != NO_OP);
	assign is_file_op = (ex_bus.op == ADD_FILE_OP) || (ex_bus.op == AND_FILE_OP);
	assign to_file    = commit && is_file_op && ex_bus.dest_file;

	// Working register: execute wins over a software write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_r <= `BYTE_ZERO;
		end else if (commit && !to_file) begin
			// Literal forms and destination bit clear land here
			w_r <= ex_bus.result;
		end else if (reg_we && (reg_addr == `REG_W_OFS)) begin
			w_r <= reg_wdata;
		end
	end

	// Status flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			c_r  <= 1'b0;
			dc_r <= 1'b0;
			z_r  <= 1'b0;
		end else if (commit) begin
			// Zero follows every one of the four
			z_r <= ex_bus.zero;
			// Carries only on the add forms, held on AND
			if (ex_bus.arith) begin
				c_r  <= ex_bus.carry;
				dc_r <= ex_bus.dcarry;
			end
		end else if (reg_we && (reg_addr == `REG_FLAGS_OFS)) begin
			c_r  <= reg_wdata[`FLAG_C_BIT];
			dc_r <= reg_wdata[`FLAG_DC_BIT];
			z_r  <= reg_wdata[`FLAG_Z_BIT];
		end
	end

	// File write port, one cycle after execute
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			file_we_r    <= 1'b0;
			file_waddr_r <= `FADDR_ZERO;
			file_wdata_r <= `BYTE_ZERO;
		end else begin
			file_we_r <= to_file;
			if (to_file) begin
				file_waddr_r <= ex_bus.faddr;
				file_wdata_r <= ex_bus.result;
			end
		end
	end

	// Prescaler clear when the timer count is overwritten
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_clr_r <= 1'b0;
		end else begin
			presc_clr_r <= to_file && psa_timer && (ex_bus.faddr == TIMER_ZERO_ADDR);
		end
	end

	// Retire pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= commit;
		end
	end

	// Control register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `CTRL_RST;
		end else if (reg_we && (reg_addr == `REG_CTRL_OFS)) begin
			// Only the two defined bits are kept
			ctrl_r <= `BYTE_ZERO;
			ctrl_r[`CTRL_EN_BIT]  <= reg_wdata[`CTRL_EN_BIT];
			ctrl_r[`CTRL_PSA_BIT] <= reg_wdata[`CTRL_PSA_BIT];
		end
	end

	// Retired count; a retire in the clearing cycle is kept
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_cnt_r <= `BYTE_ZERO;
		end else if (reg_we && (reg_addr == `REG_EXEC_OFS)) begin
			exec_cnt_r <= commit ? `CNT_ONE : `BYTE_ZERO;
		end else if (commit) begin
			exec_cnt_r <= exec_cnt_r + `CNT_ONE;
		end
	end

	// Count of held words that are not one of the four
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			foreign_cnt_r <= `BYTE_ZERO;
		end else if (reg_we && (reg_addr == `REG_FOREIGN_OFS)) begin
			foreign_cnt_r <= (ex_vld_r && (ex_bus.op == NO_OP)) ? `CNT_ONE : `BYTE_ZERO;
		end else if (ex_vld_r && (ex_bus.op == NO_OP)) begin
			foreign_cnt_r <= foreign_cnt_r + `CNT_ONE;
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= `BYTE_ZERO;
		end else if (reg_re) begin
			case (reg_addr)
				// Working register
				`REG_W_OFS: begin
					rdata_r <= w_r;
				end
				// Flags in the low three bits
				`REG_FLAGS_OFS: begin
					rdata_r <= `BYTE_ZERO;
					rdata_r[`FLAG_C_BIT]  <= c_r;
					rdata_r[`FLAG_DC_BIT] <= dc_r;
					rdata_r[`FLAG_Z_BIT]  <= z_r;
				end
				// Control
				`REG_CTRL_OFS: begin
					rdata_r <= ctrl_r;
				end
				// Counters
				`REG_EXEC_OFS: begin
					rdata_r <= exec_cnt_r;
				end
				`REG_FOREIGN_OFS: begin
					rdata_r <= foreign_cnt_r;
				end
				// Unmapped offsets read zero
				default: begin
					rdata_r <= `BYTE_ZERO;
				end
			endcase
		end else begin
			rdata_r <= `BYTE_ZERO;
		end
	end
endmodule : add_and_alu

// ### rtl/alu_cfg.svh
// Constants for the add and AND execute block
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// Instruction word layout
`define INSN_W         14
`define OPC_TOP_MSB    13
`define OPC_TOP_LSB    12
`define OPC_NIB_MSB    11
`define OPC_NIB_LSB    8
`define OPC_ADDL_LSB   9
`define DEST_BIT       7
`define FADDR_MSB      6
`define LIT_MSB        7

// Opcode field values
`define TOP_LITERAL    2'h3
`define TOP_FILE       2'h0
`define NIB_ADD_LIT    3'h7
`define NIB_AND_LIT    4'h9
`define NIB_ADD_FILE   4'h7
`define NIB_AND_FILE   4'h5

// Special file addresses (defaults of top parameters)
`define TIMER_ZERO_ADDR_DFLT 7'h01
`define PORT_A_ADDR_DFLT     7'h05
`define PORT_B_ADDR_DFLT     7'h06

// Register port offsets
`define REG_ADDR_W     3
`define REG_W_OFS      3'h0
`define REG_FLAGS_OFS  3'h1
`define REG_CTRL_OFS   3'h2
`define REG_EXEC_OFS   3'h3
`define REG_FOREIGN_OFS 3'h4

// Field positions
`define FLAG_C_BIT     0
`define FLAG_DC_BIT    1
`define FLAG_Z_BIT     2
`define CTRL_EN_BIT    0
`define CTRL_PSA_BIT   1

// Reset values and constants
`define BYTE_ZERO      8'h00
`define CNT_ONE        8'h01
`define CTRL_RST       8'h01
`define FADDR_ZERO     7'h00
`define WORD_ZERO      14'h0000

`endif

// ### rtl/alu_pkg.sv
// Types shared by the add and AND execute block
package alu_pkg;
	// Decoded operation, one-hot
	typedef enum logic [4:0] {
		NO_OP          = 5'h01,
		ADD_LITERAL_OP = 5'h02,
		AND_LITERAL_OP = 5'h04,
		ADD_FILE_OP    = 5'h08,
		AND_FILE_OP    = 5'h10
	} exec_op_t;
endpackage : alu_pkg

// ### rtl/exec_if.sv
// Signals between the top, the decoder and the arithmetic unit
interface exec_if;
	import alu_pkg::*;
	logic [13:0]    word;      // Instruction in execute
	exec_op_t       op;        // Decoded operation
	logic           dest_file; // Result goes to file register
	logic [6:0]     faddr;     // File address
	logic [7:0]     literal;   // Immediate byte
	logic [7:0]     opnd_w;    // Working register operand
	logic [7:0]     opnd_s;    // Literal or file operand
	logic [7:0]     result;    // Arithmetic result
	logic           carry;     // Carry out of bit 7
	logic           dcarry;    // Carry out of bit 3
	logic           zero;      // Result is zero
	logic           arith;     // Carry flags to be updated

	// Decoder view
	modport dec (input word, output op, dest_file, faddr, literal);
	// Arithmetic unit view
	modport alu (input op, opnd_w, opnd_s, output result, carry, dcarry, zero, arith);
	// Top view
	modport top (output word, opnd_w, opnd_s,
		input op, dest_file, faddr, literal, result, carry, dcarry, zero, arith);
endinterface : exec_if

// ### rtl/insn_decoder.sv
// Decoder for the four add and AND instruction words
`include "alu_cfg.svh"
module insn_decoder (
	exec_if.dec ex
);
	import alu_pkg::*;

	// Opcode fields
	logic [1:0] top_f;
	logic [3:0] nib_f;

	assign top_f = ex.word[`OPC_TOP_MSB:`OPC_TOP_LSB];
	assign nib_f = ex.word[`OPC_NIB_MSB:`OPC_NIB_LSB];

	// Operand fields
	assign ex.dest_file = ex.word[`DEST_BIT];
	assign ex.faddr     = ex.word[`FADDR_MSB:0];
	assign ex.literal   = ex.word[`LIT_MSB:0];

	// Opcode match, other words decode to no operation
	always_comb begin
		ex.op = NO_OP;
		if (top_f == `TOP_LITERAL) begin
			// Lowest nibble bit is a do-not-care for add literal
			if (ex.word[`OPC_NIB_MSB:`OPC_ADDL_LSB] == `NIB_ADD_LIT) begin
				ex.op = ADD_LITERAL_OP;
			end else if (nib_f == `NIB_AND_LIT) begin
				ex.op = AND_LITERAL_OP;
			end
		end else if (top_f == `TOP_FILE) begin
			if (nib_f == `NIB_ADD_FILE) begin
				ex.op = ADD_FILE_OP;
			end else if (nib_f == `NIB_AND_FILE) begin
				ex.op = AND_FILE_OP;
			end
		end
	end
endmodule : insn_decoder

// ### rtl/alu_core.sv
// Adder and AND unit with carry, digit carry and zero
`include "alu_cfg.svh"
module alu_core (
	exec_if.alu ex
);
	import alu_pkg::*;

	// Four-bit add with carry in, carry out in the top bit
	function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b, input logic ci);
		nib_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction : nib_add

	logic [4:0] lo_sum; // Low nibble sum and digit carry
	logic [4:0] hi_sum; // High nibble sum and carry

	// Ripple the two nibble adds so the digit carry is exposed
	assign lo_sum = nib_add(ex.opnd_w[3:0], ex.opnd_s[3:0], 1'b0);
	assign hi_sum = nib_add(ex.opnd_w[7:4], ex.opnd_s[7:4], lo_sum[4]);

	// Result select and flag generation
	always_comb begin
		ex.result = ex.opnd_w & ex.opnd_s;
		ex.arith  = 1'b0;
		if ((ex.op == ADD_LITERAL_OP) || (ex.op == ADD_FILE_OP)) begin
			ex.result = {hi_sum[3:0], lo_sum[3:0]};
			ex.arith  = 1'b1;
		end
		ex.carry  = hi_sum[4];
		ex.dcarry = lo_sum[4];
		ex.zero   = (ex.result == `BYTE_ZERO);
	end
endmodule : alu_core

// ### verif/add_and_alu_sva.sv
// Port-level concurrent checks for the add and AND execute block
module add_and_alu_sva #(
	parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01, // Timer count address
	parameter logic [6:0] PORT_A_ADDR     = 7'h05, // First port address
	parameter logic [6:0] PORT_B_ADDR     = 7'h06  // Second port address
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [6:0]  file_raddr,
	input wire logic [7:0]  file_rdata,
	input wire logic        file_we,
	input wire logic [6:0]  file_waddr,
	input wire logic [7:0]  file_wdata,
	input wire logic        prescaler_clr,
	input wire logic [2:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_we,
	input wire logic [7:0]  w_value,
	input wire logic        carry_flag,
	input wire logic        digit_carry_flag,
	input wire logic        zero_flag,
	input wire logic        exec_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic en_r;    // Shadow of the execute enable
	logic add_l;   // Add literal taken
	logic and_l;   // AND literal taken
	logic add_f;   // Add file taken
	logic and_f;   // AND file taken
	logic mem_src; // Source is plain storage, not a port
	logic fwd;     // Execute reads the address being written
	assign add_l = en_r && instr_valid && instr_word[13:9] == 5'h1F;
	assign and_l = en_r && instr_valid && instr_word[13:8] == 6'h39;
	assign add_f = en_r && instr_valid && instr_word[13:8] == 6'h07;
	assign and_f = en_r && instr_valid && instr_word[13:8] == 6'h05;
	assign mem_src = instr_word[6:0] != PORT_A_ADDR && instr_word[6:0] != PORT_B_ADDR;
	assign fwd = file_we && file_waddr == file_raddr;
	// Follow the enable bit so disabled cycles raise no alarm
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_r <= 1'b1;
		end else if (reg_we && reg_addr == 3'h2) begin
			en_r <= reg_wdata[0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	retire_timing_a: assert property ((add_l || and_l) |-> ##2 exec_done && !file_we)
		else $error("literal retire timing wrong");
	retire_cause_a: assert property (exec_done |-> $past(add_l || and_l || add_f || and_f, 2))
		else $error("retire without instruction");
	add_lit_sum_a: assert property (add_l |-> ##2 {carry_flag, w_value} ==
		{1'b0, $past(w_value)} + {1'b0, $past(instr_word[7:0], 2)})
		else $error("literal add result wrong");
	add_lit_dc_a: assert property (add_l |-> ##2 digit_carry_flag ==
		(({1'b0, $past(w_value[3:0])} + {1'b0, $past(instr_word[3:0], 2)}) > 5'h0F))
		else $error("literal add digit carry wrong");
	and_lit_a: assert property (and_l |-> ##2 w_value == ($past(w_value) & $past(instr_word[7:0], 2))
		&& $stable(carry_flag) && $stable(digit_carry_flag))
		else $error("literal and wrong");
	zero_flag_a: assert property (exec_done |-> zero_flag == ((file_we ? file_wdata : w_value) == 8'h00))
		else $error("zero flag wrong");
	file_dest_a: assert property ((add_f || and_f) |-> ##2 file_we == $past(instr_word[7], 2)
		&& (!file_we || file_waddr == $past(instr_word[6:0], 2)))
		else $error("destination wrong");
	read_addr_a: assert property ((add_f || and_f) |=> file_raddr == $past(instr_word[6:0]))
		else $error("file read address wrong");
	and_file_a: assert property (and_f && mem_src |-> ##2 $past(fwd) ||
		(file_we ? file_wdata : w_value) == ($past(w_value) & $past(file_rdata)))
		else $error("file and wrong");
	add_file_a: assert property (add_f && mem_src |-> ##2 $past(fwd) || {carry_flag, (file_we ? file_wdata : w_value)}
		== {1'b0, $past(w_value)} + {1'b0, $past(file_rdata)})
		else $error("file add wrong");
	prescaler_a: assert property (prescaler_clr |-> file_we && file_waddr == TIMER_ZERO_ADDR)
		else $error("prescaler clear misplaced");
endmodule : add_and_alu_sva

bind add_and_alu add_and_alu_sva #(.TIMER_ZERO_ADDR(TIMER_ZERO_ADDR), .PORT_A_ADDR(PORT_A_ADDR),
	.PORT_B_ADDR(PORT_B_ADDR)) chk (.ref_clk, .rst_n, .instr_valid, .instr_word, .file_raddr, .file_rdata,
	.file_we, .file_waddr, .file_wdata, .prescaler_clr, .reg_addr, .reg_wdata, .reg_we, .w_value,
	.carry_flag, .digit_carry_flag, .zero_flag, .exec_done);

// ### verif/file_array.sv
// Behavioural data file array facing the execute block
module file_array (
	input wire logic       ref_clk,
	input wire logic [6:0] raddr,
	output logic     [7:0] rdata,
	input wire logic       we,
	input wire logic [6:0] waddr,
	input wire logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [128]; // Storage, preloaded by the bench
	// Read answers in the same cycle
	assign rdata = mem[raddr];
	// Write lands at the end of the strobe cycle
	always @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule : file_array

// ### verif/add_and_alu_test.sv
// Self-checking bench for the add and AND execute block
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module add_and_alu_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] c; logic [7:0] w; logic [2:0] f; logic [13:0] wd;} case_t;
	logic        ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0]  port_a_pins = 8'h3C, port_b_pins = 8'hA5, reg_wdata = 8'h00;
	logic [2:0]  reg_addr = 3'h0;
	logic [6:0]  file_raddr, file_waddr;
	logic [7:0]  file_rdata, file_wdata, reg_rdata, w_value;
	logic        file_we, prescaler_clr, carry_flag, digit_carry_flag, zero_flag, exec_done;
	logic [7:0]  ew;                    // Expected working register
	logic        ec, edc, ez, psa;      // Expected flags, prescaler assignment
	int          failures = 0;
	int          cmp_count = 0;
	case_t       cases [12] = '{
		'{8'h01, 8'h10, 3'h0, 14'h3E15}, '{8'h01, 8'hF8, 3'h0, 14'h3F08},
		'{8'h01, 8'hA3, 3'h3, 14'h395F}, '{8'h01, 8'hA3, 3'h3, 14'h3900},
		'{8'h01, 8'h17, 3'h0, 14'h0704}, '{8'h01, 8'h17, 3'h7, 14'h0584},
		'{8'h01, 8'h01, 3'h0, 14'h0705}, '{8'h01, 8'hFF, 3'h0, 14'h0706},
		'{8'h01, 8'h0F, 3'h0, 14'h07A0}, '{8'h01, 8'hFF, 3'h0, 14'h0581},
		'{8'h03, 8'hF0, 3'h0, 14'h0581}, '{8'h03, 8'hF0, 3'h0, 14'h0501}};
	add_and_alu dut (.ref_clk, .rst_n, .instr_valid, .instr_word, .file_raddr, .file_rdata, .file_we,
		.file_waddr, .file_wdata, .port_a_pins, .port_b_pins, .prescaler_clr, .reg_addr, .reg_wdata,
		.reg_we, .reg_re, .reg_rdata, .w_value, .carry_flag, .digit_carry_flag, .zero_flag, .exec_done);
	file_array fa (.ref_clk, .raddr(file_raddr), .rdata(file_rdata), .we(file_we), .waddr(file_waddr),
		.wdata(file_wdata));
	// Verdict and end of run
	task automatic close_out();
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// One-cycle register write
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask : reg_wr
	// One-cycle register read, data checked in the following cycle
	task automatic reg_rd(input logic [2:0] a, input logic [7:0] ex, input string nm);
		@(posedge ref_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		#1;
		`CHK(nm, ex, reg_rdata)
		// Read data stands for one cycle only
		@(posedge ref_clk);
		#1;
		`CHK(nm, 8'h00, reg_rdata)
	endtask : reg_rd
	// Load control, working register and flags
	task automatic set_state(input case_t k);
		reg_wr(3'h2, k.c);
		reg_wr(3'h0, k.w);
		reg_wr(3'h1, {5'h00, k.f});
		ew = k.w;
		{ez, edc, ec} = k.f;
		psa = k.c[1];
	endtask : set_state
	// Issue one word and check its execute and retire cycles
	task automatic run(input logic [13:0] wd);
		logic [7:0] op;
		logic [8:0] s;
		logic [7:0] r;
		logic       fop;
		logic       dst;
		logic       add;
		fop = wd[13:12] == 2'h0;
		dst = fop && wd[7];
		add = fop ? wd[9] : wd[10];
		op = !fop ? wd[7:0] : wd[6:0] == 7'h05 ? port_a_pins : wd[6:0] == 7'h06 ? port_b_pins : fa.mem[wd[6:0]];
		s = {1'b0, ew} + {1'b0, op};
		r = add ? s[7:0] : ew & op;
		if (add) begin
			edc = ({1'b0, ew[3:0]} + {1'b0, op[3:0]}) > 5'h0F;
			ec = s[8];
		end
		ez = r == 8'h00;
		if (!dst) begin
			ew = r;
		end
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= wd;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		if (fop) `CHK("file_raddr", wd[6:0], file_raddr)
		@(posedge ref_clk);
		#1;
		`CHK("exec_done", 1'b1, exec_done)
		`CHK("w_value", ew, w_value)
		`CHK("carry_flag", ec, carry_flag)
		`CHK("digit_carry_flag", edc, digit_carry_flag)
		`CHK("zero_flag", ez, zero_flag)
		`CHK("file_we", dst, file_we)
		if (dst) `CHK("file_wdata", {wd[6:0], r}, {file_waddr, file_wdata})
		`CHK("prescaler_clr", dst && wd[6:0] == 7'h01 && psa, prescaler_clr)
	endtask : run
	// Free-running clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// Cuts a hang short
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		close_out();
	end
	// Main sequence
	initial begin
		fa.mem[1] = 8'h5A;
		fa.mem[4] = 8'hC2;
		fa.mem[5] = 8'h11;
		fa.mem[6] = 8'h22;
		fa.mem[32] = 8'h01;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		reg_rd(3'h0, 8'h00, "w_reset");
		reg_rd(3'h2, 8'h01, "ctrl_reset");
		reg_wr(3'h5, 8'hFF);
		reg_rd(3'h5, 8'h00, "unmapped");
		reg_wr(3'h3, 8'h00);
		foreach (cases[i]) begin
			set_state(cases[i]);
			run(cases[i].wd);
		end
		// Execution disabled: nothing retires and W is left alone
		reg_wr(3'h2, 8'h00);
		reg_rd(3'h2, 8'h00, "ctrl_off");
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= 14'h3E01;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK("exec_done_off", 1'b0, exec_done)
		`CHK("w_off", ew, w_value)
		reg_rd(3'h3, 8'h0C, "retired_count");
		reg_wr(3'h2, 8'h01);
		// A software write to W in the retire cycle loses to execute
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= 14'h3E01;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		reg_we <= 1'b1;
		reg_addr <= 3'h0;
		reg_wdata <= 8'hAA;
		@(posedge ref_clk);
		reg_we <= 1'b0;
		#1;
		`CHK("w_exec_wins", 8'h51, w_value)
		// Back-to-back file adds: the second reads the forwarded result
		reg_wr(3'h0, 8'h01);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= 14'h07A0;
		@(posedge ref_clk);
		instr_word <= 14'h0720;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("w_forward", 8'h12, w_value)
		// Flags keep only their three bits
		reg_wr(3'h1, 8'hFF);
		reg_rd(3'h1, 8'h07, "flags_rw");
		reg_wr(3'h0, 8'h55);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= 14'h3800;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		reg_rd(3'h0, 8'h55, "w_after_foreign");
		reg_rd(3'h4, 8'h01, "foreign_count");
		close_out();
	end
endmodule : add_and_alu_test
